// [rtl/pwmcci_top.sv]
`timescale 1ns/10ps
// Functional notes
// R1 - Setting pattern enable starts script at first command; clearing stops it.
// R2 - Device clears pattern enable after an end command with reset flag.
// R3 - After host clears enable, current command finishes before stopping.
// R4 - Output enable low holds off level; high follows generated pattern.
// R5 - Off level bit: zero drives low, one drives high, while disabled.
// R6 - Soft reset register bits 2..0 reset timers 2..0; zeros do nothing.
// R7 - Soft reset rewinds pattern generator to first pattern and stops it.
// R8 - Soft reset halts every state machine and timer of that channel.
// R9 - Soft reset leaves stored script patterns untouched.
// R10 - Soft reset keeps pending interrupts; host clears them via clear register.
// R11 - Raw status register reports unmasked state; bits 7..6 read zero.
// R12 - Pattern-done flags for timers 2..0 sit at bits 5..3, reset zero.
// R13 - Cycle-done flags for timers 2..0 sit at bits 2..0, reset zero.
// R14 - Cycle-done raised when the active command's PWM cycle ends.
// R15 - Pattern-done raised when a script task completes.
// R16 - Timer config bit 4 masks the cycle-done interrupt when one.
// R17 - Masked status is raw status gated by both masks; drives irq.
// R18 - Raw flags stay set regardless of mask until host clears them.
module pwmcci_top #(
   parameter int TICK_DIV = pwmcci_pkg::TICK_DIV_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pwmcci_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [pwmcci_pkg::AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pwmcci_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [pwmcci_pkg::AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [pwmcci_pkg::SCRIPT_AW-1:0] script_addr [pwmcci_pkg::NUM_CH],
   input wire logic [pwmcci_pkg::DUTY_W-1:0] script_duty [pwmcci_pkg::NUM_CH],
   input wire logic [pwmcci_pkg::NUM_CH-1:0] script_end,
   input wire logic [pwmcci_pkg::NUM_CH-1:0] script_end_rst,
   output logic [pwmcci_pkg::NUM_CH-1:0] pwm_out,
   output logic irq
);
   import pwmcci_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data may arrive in either order

   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] wr_idx_reg;
   logic [REG_W-1:0] wdata_reg;
   logic wstrb0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic do_write;
   logic wr_lane;
   logic wr_soft_reset;
   logic wr_irq_clear;
   logic wr_fixed_hit;
   logic [NUM_CH-1:0] wr_ctrl_hit;
   logic [NUM_CH-1:0] wr_cfg_hit;
   logic wr_mapped;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   // Only the low byte lane carries register data
   assign wr_lane = do_write && wstrb0_reg;
   assign wr_soft_reset = wr_lane && (wr_idx_reg == IDX_SOFT_RESET);
   assign wr_irq_clear = wr_lane && (wr_idx_reg == IDX_IRQ_CLEAR);
   // Status registers accept writes silently so software never sees an error
   assign wr_fixed_hit = (wr_idx_reg == IDX_SOFT_RESET) || (wr_idx_reg == IDX_IRQ_CLEAR)
                         || (wr_idx_reg == IDX_RAW_IRQ) || (wr_idx_reg == IDX_MASKED_IRQ);
   assign wr_mapped = wr_fixed_hit || (|wr_ctrl_hit) || (|wr_cfg_hit);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         wr_idx_reg <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_reg <= 1'b1;
         wr_idx_reg <= s_axi_awaddr[9:2];
      end
      else if (do_write)
      begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_reg <= 1'b1;
         wdata_reg <= s_axi_wdata[REG_W-1:0];
         wstrb0_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
      begin
         w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel registers, raw flags and channel engines

   logic [CTRL_W-1:0] ctrl_reg [NUM_CH];
   logic [NUM_CH-1:0] cyc_mask_reg;
   logic [NUM_CH-1:0] raw_cyc_reg;
   logic [NUM_CH-1:0] raw_pat_reg;
   logic [NUM_CH-1:0] msk_cyc;
   logic [NUM_CH-1:0] msk_pat;
   logic [NUM_CH-1:0] rd_ctrl_hit;
   logic [NUM_CH-1:0] rd_cfg_hit;
   logic [REG_W-1:0] rd_ch_data [NUM_CH];
   logic [7:0] rd_idx;
   logic tick;

   pwmcci_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   generate
      for (genvar c = 0; c < NUM_CH; c++)
      begin : g_ch
         localparam logic [7:0] CTRL_IDX = 8'(IDX_CHAN_CTRL0 + 8'(c) * IDX_CH_STRIDE);
         localparam logic [7:0] CFG_IDX = 8'(IDX_TIMER_CFG0 + 8'(c) * IDX_CH_STRIDE);
         logic soft_rst;
         logic clr_cyc;
         logic clr_pat;
         pwmcci_chan_if ch_if ();

         assign wr_ctrl_hit[c] = (wr_idx_reg == CTRL_IDX);
         assign wr_cfg_hit[c] = (wr_idx_reg == CFG_IDX);
         assign rd_ctrl_hit[c] = (rd_idx == CTRL_IDX);
         assign rd_cfg_hit[c] = (rd_idx == CFG_IDX);
         assign soft_rst = wr_soft_reset && wdata_reg[c]; // [R6]
         assign clr_cyc = wr_irq_clear && wdata_reg[IRQ_CYC_LSB + c];
         assign clr_pat = wr_irq_clear && wdata_reg[IRQ_PAT_LSB + c];

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               ctrl_reg[c] <= CTRL_RESET;
            end
            else if (wr_lane && wr_ctrl_hit[c])
            begin
               ctrl_reg[c] <= wdata_reg[CTRL_W-1:0]; // [R1]
            end
            else if (soft_rst || ch_if.clear_enable)
            begin
               // Device-side stop; a host write in the same cycle wins [R2] [R7]
               ctrl_reg[c][CTL_PGEN_BIT] <= 1'b0;
            end
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cyc_mask_reg[c] <= 1'b0;
            end
            else if (wr_lane && wr_cfg_hit[c])
            begin
               cyc_mask_reg[c] <= wdata_reg[CFG_CDONE_MASK_BIT]; // [R16]
            end
         end

         // Flags ignore masks and soft reset; a new event beats a clear
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               raw_cyc_reg[c] <= 1'b0;
               raw_pat_reg[c] <= 1'b0;
            end
            else
            begin
               raw_cyc_reg[c] <= ch_if.cycle_done || (raw_cyc_reg[c] && !clr_cyc); // [R13] [R14] [R18] [R10]
               raw_pat_reg[c] <= ch_if.pattern_done || (raw_pat_reg[c] && !clr_pat); // [R12] [R15] [R18] [R10]
            end
         end

         assign msk_cyc[c] = raw_cyc_reg[c] && !cyc_mask_reg[c]; // [R17]
         assign msk_pat[c] = raw_pat_reg[c] && !ctrl_reg[c][CTL_PDONE_MASK_BIT]; // [R17]

         // Script memory lives outside and is never touched by a soft reset [R9]
         assign ch_if.enable = ctrl_reg[c][CTL_PGEN_BIT];
         assign ch_if.soft_reset = soft_rst; // [R8]
         assign ch_if.cmd_duty = script_duty[c];
         assign ch_if.cmd_end = script_end[c];
         assign ch_if.cmd_end_rst = script_end_rst[c];
         assign script_addr[c] = ch_if.cmd_index;

         pwmcci_channel u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick),
            .bus(ch_if.chan)
         );

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               pwm_out[c] <= 1'b0;
            end
            else
            begin
               pwm_out[c] <= ctrl_reg[c][CTL_OUT_EN_BIT] ? ch_if.pattern // [R4]
                                                         : ctrl_reg[c][CTL_OFF_LEVEL_BIT]; // [R5]
            end
         end

         assign rd_ch_data[c] = rd_ctrl_hit[c] ? REG_W'(ctrl_reg[c])
                              : rd_cfg_hit[c] ? REG_W'({cyc_mask_reg[c], 4'h0}) : 8'h00;
      end
   endgenerate

   assign irq = |{msk_pat, msk_cyc}; // [R17]

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, data from a register

   logic rvalid_reg;
   logic [REG_W-1:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [REG_W-1:0] raw_word;
   logic [REG_W-1:0] masked_word;
   logic [REG_W-1:0] ch_word;
   logic rd_fixed_hit;
   logic rd_mapped;
   logic [REG_W-1:0] rd_word;

   assign rd_idx = s_axi_araddr[9:2];
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = AXI_DW'(rdata_reg);

   assign raw_word = {2'b00, raw_pat_reg, raw_cyc_reg}; // [R11] [R12] [R13]
   assign masked_word = {2'b00, msk_pat, msk_cyc};
   assign ch_word = rd_ch_data[0] | rd_ch_data[1] | rd_ch_data[2];
   // Soft reset and clear registers are write-only and read as zero
   assign rd_fixed_hit = (rd_idx == IDX_RAW_IRQ) || (rd_idx == IDX_MASKED_IRQ)
                         || (rd_idx == IDX_SOFT_RESET) || (rd_idx == IDX_IRQ_CLEAR);
   assign rd_mapped = rd_fixed_hit || (|rd_ctrl_hit) || (|rd_cfg_hit);
   assign rd_word = (rd_idx == IDX_RAW_IRQ) ? raw_word
                  : (rd_idx == IDX_MASKED_IRQ) ? masked_word : ch_word;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rresp_reg <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule : pwmcci_top

// [rtl/pwmcci_pkg.sv]
package pwmcci_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Structure
   localparam int NUM_CH = 3;
   localparam int REG_W = 8;
   localparam int AXI_AW = 12;
   localparam int AXI_DW = 32;
   localparam int SCRIPT_AW = 5;
   localparam int DUTY_W = 8;
   localparam int CTRL_W = 4;
   localparam int TICK_DIV_DEFAULT = 100;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TIMER_CFG0 = 8'h60;
   localparam logic [7:0] IDX_CHAN_CTRL0 = 8'h61;
   localparam logic [7:0] IDX_CH_STRIDE = 8'h08;
   localparam logic [7:0] IDX_SOFT_RESET = 8'h78;
   localparam logic [7:0] IDX_RAW_IRQ = 8'h7A;
   localparam logic [7:0] IDX_MASKED_IRQ = 8'h7B;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'h7C;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_OFF_LEVEL_BIT = 0;
   localparam int CTL_OUT_EN_BIT = 1;
   localparam int CTL_PGEN_BIT = 2;
   localparam int CTL_PDONE_MASK_BIT = 3;
   localparam int CFG_CDONE_MASK_BIT = 4;
   localparam int IRQ_CYC_LSB = 0;
   localparam int IRQ_PAT_LSB = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and bus answers
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [DUTY_W-1:0] PWM_LAST_STEP = 8'hFF;

   typedef enum logic {
      PWMCCI_ST_IDLE = 1'b0,
      PWMCCI_ST_RUN = 1'b1
   } pwmcci_state_t;

endpackage : pwmcci_pkg

// [rtl/pwmcci_chan_if.sv]
`timescale 1ns/10ps
interface pwmcci_chan_if;
   import pwmcci_pkg::*;

   logic enable;
   logic soft_reset;
   logic [DUTY_W-1:0] cmd_duty;
   logic cmd_end;
   logic cmd_end_rst;
   logic [SCRIPT_AW-1:0] cmd_index;
   logic pattern;
   logic cycle_done;
   logic pattern_done;
   logic clear_enable;

   modport ctrl (
      output enable,
      output soft_reset,
      output cmd_duty,
      output cmd_end,
      output cmd_end_rst,
      input cmd_index,
      input pattern,
      input cycle_done,
      input pattern_done,
      input clear_enable
   );

   modport chan (
      input enable,
      input soft_reset,
      input cmd_duty,
      input cmd_end,
      input cmd_end_rst,
      output cmd_index,
      output pattern,
      output cycle_done,
      output pattern_done,
      output clear_enable
   );

endinterface : pwmcci_chan_if

// [rtl/pwmcci_tick.sv]
`timescale 1ns/10ps
module pwmcci_tick #(
   parameter int DIV = pwmcci_pkg::TICK_DIV_DEFAULT
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   import pwmcci_pkg::*;

   localparam int CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);

   logic [CNT_W-1:0] cnt_reg;
   logic wrap;

   generate
      if (DIV < 1)
      begin : g_bad_div
         $error("pwmcci_tick: DIV must be at least 1");
      end
   endgenerate

   assign wrap = (cnt_reg == CNT_LAST);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg <= '0;
         tick <= 1'b0;
      end
      else
      begin
         cnt_reg <= wrap ? '0 : cnt_reg + CNT_W'(1);
         tick <= wrap;
      end
   end

endmodule : pwmcci_tick

// [rtl/pwmcci_channel.sv]
`timescale 1ns/10ps
module pwmcci_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   pwmcci_chan_if.chan bus
);
   import pwmcci_pkg::*;

   pwmcci_state_t state_reg;
   logic [DUTY_W-1:0] step_reg;
   logic cycle_end;
   logic go_on;

   // One command lasts one full PWM cycle of 256 ticks
   assign cycle_end = (state_reg == PWMCCI_ST_RUN) && tick && (step_reg == PWM_LAST_STEP);
   // Stop only at a command boundary [R3]
   assign go_on = bus.enable && !(bus.cmd_end && bus.cmd_end_rst);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= PWMCCI_ST_IDLE;
         step_reg <= '0;
         bus.cmd_index <= '0;
         bus.pattern <= 1'b0;
         bus.cycle_done <= 1'b0;
         bus.pattern_done <= 1'b0;
         bus.clear_enable <= 1'b0;
      end
      else if (bus.soft_reset)
      begin
         // Halt everything and rewind to the first pattern [R7] [R8]
         state_reg <= PWMCCI_ST_IDLE;
         step_reg <= '0;
         bus.cmd_index <= '0;
         bus.pattern <= 1'b0;
         bus.cycle_done <= 1'b0;
         bus.pattern_done <= 1'b0;
         bus.clear_enable <= 1'b0;
      end
      else
      begin
         bus.cycle_done <= cycle_end; // [R14]
         bus.pattern_done <= cycle_end && bus.cmd_end; // [R15]
         bus.clear_enable <= cycle_end && bus.cmd_end && bus.cmd_end_rst; // [R2]
         bus.pattern <= (state_reg == PWMCCI_ST_RUN) && (step_reg < bus.cmd_duty);
         unique case (state_reg)
            PWMCCI_ST_IDLE:
            begin
               // Enable bit still reads one while its own clear is pending [R2]
               if (bus.enable && !bus.clear_enable)
               begin
                  state_reg <= PWMCCI_ST_RUN; // [R1]
                  step_reg <= '0;
                  bus.cmd_index <= '0;
               end
            end
            PWMCCI_ST_RUN:
            begin
               if (tick)
               begin
                  step_reg <= step_reg + DUTY_W'(1);
               end
               if (cycle_end)
               begin
                  if (!go_on)
                  begin
                     state_reg <= PWMCCI_ST_IDLE; // [R1] [R3]
                     bus.cmd_index <= '0;
                  end
                  else if (bus.cmd_end)
                  begin
                     bus.cmd_index <= '0;
                  end
                  else
                  begin
                     bus.cmd_index <= bus.cmd_index + SCRIPT_AW'(1);
                  end
               end
            end
         endcase
      end
   end

endmodule : pwmcci_channel

// [verification/pwmcci_top_chk.sv]
`timescale 1ns/10ps
module pwmcci_top_chk #(
   parameter int TICK_DIV = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [pwmcci_pkg::AXI_DW-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [pwmcci_pkg::SCRIPT_AW-1:0] script_addr [pwmcci_pkg::NUM_CH],
   input wire logic [pwmcci_pkg::NUM_CH-1:0] pwm_out,
   input wire logic irq
);
   import pwmcci_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////
   // Write path: both halves taken together, answer follows
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      ##[1:2] s_axi_bvalid;
   endsequence

   a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write not answered in time");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed early");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
      else $error("reserved status bits set");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");

   ////////////////////////////////////////////////////////////////////////////
   // Channel side
   a_reset_quiet: assert property ($rose(aresetn) |->
      pwm_out == 3'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   // Index only steps forward by one or rewinds to the first command
   a_index_step: assert property ($changed(script_addr[0]) |->
      script_addr[0] == 5'h0 || script_addr[0] == $past(script_addr[0]) + 5'h1)
      else $error("command index jumped");

endmodule : pwmcci_top_chk

bind pwmcci_top pwmcci_top_chk #(.TICK_DIV(TICK_DIV)) i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .script_addr(script_addr),
   .pwm_out(pwm_out), .irq(irq)
);

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
   import pwmcci_pkg::*;

   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [AXI_DW-1:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [SCRIPT_AW-1:0] s_addr [NUM_CH];
   logic [DUTY_W-1:0] s_duty [NUM_CH];
   logic [NUM_CH-1:0] s_end, end_rst, pwm_out;
   logic [33:0] rd_q [$];
   logic [1:0] wr_q [$];
   logic [8:0] cnt;
   logic [7:0] v;
   int n_errors;
   int n_tests;

   pwmcci_top #(.TICK_DIV(1)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .script_addr(s_addr), .script_duty(s_duty), .script_end(s_end),
      .script_end_rst(end_rst), .pwm_out(pwm_out), .irq(irq));

   // Script store: one duty per channel, so any 256-cycle window sees the same count
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_store
      assign s_end[c] = (s_addr[c] == 5'h1);
   end

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : tally
   task automatic check_read(input logic [33:0] got, input logic [33:0] exp);
      tally(got === exp, $sformatf("read %h expected %h", got, exp));
   endtask : check_read
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      tally(got === exp, $sformatf("write answer %h expected %h", got, exp));
   endtask : check_resp
   task automatic check_level(input logic got, input logic exp);
      tally(got === exp, $sformatf("level %b expected %b", got, exp));
   endtask : check_level
   task automatic check_word(input logic [8:0] got, input logic [8:0] exp);
      tally(got === exp, $sformatf("count %h expected %h", got, exp));
   endtask : check_word

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   function automatic logic [7:0] ctl(input int c);
      return IDX_CHAN_CTRL0 + 8'(c) * IDX_CH_STRIDE;
   endfunction : ctl
   function automatic logic [7:0] cfg(input int c);
      return IDX_TIMER_CFG0 + 8'(c) * IDX_CH_STRIDE;
   endfunction : cfg

   // Looks at the level on the falling edge, which is what the next rising edge samples
   task automatic wait_hi(input int k);
      logic g;
      do
      begin
         @(negedge aclk);
         g = (k == 0) ? bvalid : (k == 1) ? arready : rvalid;
         @(posedge aclk);
      end
      while (g !== 1'b1);
   endtask : wait_hi

   task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
      logic a;
      logic w;
      wr_q.push_back(r);
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w))
      begin
         @(negedge aclk);
         a = a || awready;
         w = w || wready;
         @(posedge aclk);
         if (a)
            awvalid <= 1'b0;
         if (w)
            wvalid <= 1'b0;
      end
      wait_hi(0);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
      rd_q.push_back({r, 24'h0, d});
      @(posedge aclk);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      wait_hi(1);
      arvalid <= 1'b0;
      wait_hi(2);
      rready <= 1'b0;
   endtask : axi_read

   always @(posedge aclk)
   begin
      if (bvalid && bready && wr_q.size() > 0)
         check_resp(bresp, wr_q.pop_front());
      if (rvalid && rready && rd_q.size() > 0)
         check_read({rresp, rdata}, rd_q.pop_front());
   end

   // Whole run is near 2000 cycles; five times that means a hang
   initial
   begin
      repeat (10000) @(posedge aclk);
      n_errors++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      end_rst = 3'b001;
      n_errors = 0;
      n_tests = 0;
      void'($urandom(32'h9AD1B68F));
      for (int c = 0; c < NUM_CH; c++)
         s_duty[c] = 8'($urandom_range(240, 16));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int c = 0; c < NUM_CH; c++)
      begin
         axi_read(ctl(c), 8'h00, RESP_OKAY);
         axi_read(cfg(c), 8'h00, RESP_OKAY);
      end
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      axi_write(IDX_RAW_IRQ, 8'hFF, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      axi_read(IDX_SOFT_RESET, 8'h00, RESP_OKAY);
      axi_write(8'h10, 8'hFF, RESP_SLVERR);
      axi_read(8'h10, 8'h00, RESP_SLVERR);
      $display("test register map finished");
      for (int c = 0; c < NUM_CH; c++)
         for (int p = 0; p < 2; p++)
         begin
            v = (8'($urandom) & 8'h0A) | 8'(p);
            axi_write(ctl(c), v, RESP_OKAY);
            axi_read(ctl(c), v, RESP_OKAY);
            @(negedge aclk);
            check_level(pwm_out[c], v[1] ? 1'b0 : v[0]);
            axi_write(ctl(c), 8'h00, RESP_OKAY);
         end
      $display("test off level finished");
      axi_write(ctl(0), 8'h06, RESP_OKAY);
      repeat (10) @(posedge aclk);
      cnt = 9'h0;
      repeat (256)
      begin
         @(negedge aclk);
         cnt = cnt + 9'(pwm_out[0]);
      end
      check_word(cnt, {1'b0, s_duty[0]});
      check_word({4'h0, s_addr[0]}, 9'h001);
      repeat (300) @(posedge aclk);
      axi_read(ctl(0), 8'h02, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h09, RESP_OKAY);
      @(negedge aclk);
      check_word({4'h0, s_addr[0]}, 9'h000);
      check_level(irq, 1'b1);
      $display("test script run finished");
      axi_write(cfg(0), 8'h10, RESP_OKAY);
      @(negedge aclk);
      check_level(irq, 1'b1);
      axi_write(ctl(0), 8'h08, RESP_OKAY);
      @(negedge aclk);
      check_level(irq, 1'b0);
      axi_read(IDX_MASKED_IRQ, 8'h00, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h09, RESP_OKAY);
      axi_write(cfg(0), 8'h00, RESP_OKAY);
      axi_write(IDX_IRQ_CLEAR, 8'h3F, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      $display("test masks finished");
      axi_write(ctl(1), 8'h04, RESP_OKAY);
      repeat (100) @(posedge aclk);
      axi_write(ctl(1), 8'h00, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      repeat (200) @(posedge aclk);
      axi_read(IDX_RAW_IRQ, 8'h02, RESP_OKAY);
      axi_write(IDX_IRQ_CLEAR, 8'h3F, RESP_OKAY);
      repeat (300) @(posedge aclk);
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      $display("test late stop finished");
      axi_write(ctl(2), 8'h06, RESP_OKAY);
      repeat (300) @(posedge aclk);
      axi_read(IDX_RAW_IRQ, 8'h04, RESP_OKAY);
      axi_write(IDX_SOFT_RESET, 8'h04, RESP_OKAY);
      axi_read(ctl(2), 8'h02, RESP_OKAY);
      axi_read(IDX_RAW_IRQ, 8'h04, RESP_OKAY);
      @(negedge aclk);
      check_word({4'h0, s_addr[2]}, 9'h000);
      axi_write(IDX_IRQ_CLEAR, 8'h3F, RESP_OKAY);
      repeat (300) @(posedge aclk);
      axi_read(IDX_RAW_IRQ, 8'h00, RESP_OKAY);
      @(negedge aclk);
      check_level(pwm_out[2], 1'b0);
      $display("test soft reset finished");
      repeat (5) @(posedge aclk);
      summarize();
   end

endmodule : tb
